// ==== verilog/pdf_consts.vh ====
// Constants for the port D and port F pin function multiplexer.
`ifndef PDF_CONSTS_VH
`define PDF_CONSTS_VH
`define PDF_PORTF_W 4
`define PDF_PORTD_W 6
`define PDF_PORTF_ALL_ON 4'hF
`define PDF_PORTD_ALL_ON 6'h3F
`define PDF_PORTF_ZERO 4'h0
`define PDF_PORTD_ZERO 6'h00
`define PDF_SEL_W 8
`define PDF_SEL_RESET 8'h00
`define PDF_SEL_PIN0_BIT 4
`define PDF_SEL_PIN1_BIT 5
`define PDF_PIN0 0
`define PDF_PIN1 1
`define PDF_PIN2 2
`define PDF_PIN3 3
`define PDF_PIN4 4
`define PDF_PIN5 5
`define PDF_CS_FOR_PIN0 2
`define PDF_CS_FOR_PIN1 3
`define PDF_CS_FOR_PIN2 4
`define PDF_CS_FOR_PIN3 5
`define PDF_CS_FOR_PIN4 6
`define PDF_CS_FOR_PIN5 7
`define PDF_CS_LO 2
`define PDF_CS_HI 5
`define PDF_FUNC_W 2
`define PDF_FUNC_GPIO 2'h1
`define PDF_FUNC_PERIPH 2'h2
`endif

// ==== verilog/pdf_sync2.v ====
// Two flip-flop synchroniser for one pin input.
`timescale 1ns/100ps
module pdf_sync2 (
  input wire clk,
  input wire reset,
  input wire async_in,
  output reg sync_out
);
  reg stage1;

  always @(posedge clk) begin
    if (reset) begin
      stage1 <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // pdf_sync2

// ==== verilog/pdf_pin_cell.v ====
// One generic pin cell: selects between GPIO and a peripheral drive, registers the pad controls.
`timescale 1ns/100ps
module pdf_pin_cell (
  input wire clk,
  input wire reset,
  input wire periph_sel,
  input wire gpio_dir,
  input wire gpio_data,
  input wire periph_out,
  input wire periph_oe,
  input wire pullup_en,
  input wire pin_in,
  output reg pad_out,
  output reg pad_oe,
  output reg pad_pullup,
  output wire pin_value
);
  always @(posedge clk) begin
    if (reset) begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
      pad_pullup <= 1'b1;
    end else begin
      pad_out <= periph_sel ? periph_out : gpio_data;
      pad_oe <= periph_sel ? periph_oe : gpio_dir;
      pad_pullup <= pullup_en;
    end
  end

  pdf_sync2 u_sync (
    .clk(clk),
    .reset(reset),
    .async_in(pin_in),
    .sync_out(pin_value)
  );
endmodule // pdf_pin_cell

// ==== verilog/pdf_pin_mux.v ====
// Pin function multiplexer for four port F pins and six port D pins.
//
// Functional notes
// [RULE1] Data bus pins float while external bus idle; here a set bus_drive_control_bit with ext_data_write drives them.
// [RULE2] Data pins reset to bus function; reprogram.
// [RULE3] Cleared port F pull-up bit disables pull-up.
// [RULE4] Each GPIO pin individually input or output.
// [RULE5] Pin 0: enable bit 0, select bit 4.
// [RULE6] Pin 1: enable bit 1, select bit 5.
// [RULE7] Chip selects follow interface region decode.
// [RULE8] Chip selects float while external bus idle; here a set bus_drive_control_bit keeps them driven.
// [RULE9] Port D pins 2 to 5 reset GPIO.
// [RULE10] Cleared port D pull-up bit disables pull-up.
// [RULE11] CAN receive keeps pull-up always active.
// [RULE12] Cleared enable returns pin to GPIO.
`timescale 1ns/100ps
`include "pdf_consts.vh"
module pdf_pin_mux (
  input wire clk,
  input wire reset,
  input wire [3:0] port_f_pullup_enable,
  input wire [3:0] port_f_gpio_enable,
  input wire [3:0] port_f_direction,
  input wire [3:0] port_f_data_out,
  input wire [5:0] port_d_pullup_enable,
  input wire [5:0] port_d_peripheral_enable,
  input wire [5:0] port_d_direction,
  input wire [5:0] port_d_data_out,
  input wire [7:0] system_function_select,
  input wire bus_drive_control_bit,
  input wire ext_bus_active,
  input wire [3:0] ext_data_out,
  input wire ext_data_write,
  input wire [7:2] chip_select_n,
  input wire can_second_transmit,
  input wire [3:0] port_f_pin_in,
  input wire [5:0] port_d_pin_in,
  output wire [3:0] port_f_pin_out,
  output wire [3:0] port_f_pin_oe,
  output wire [3:0] port_f_pin_pullup,
  output wire [5:0] port_d_pin_out,
  output wire [5:0] port_d_pin_oe,
  output wire [5:0] port_d_pin_pullup,
  output reg [3:0] port_f_data_in,
  output reg [3:0] ext_data_in,
  output reg [5:0] port_d_data_in,
  output reg can_second_receive
);
  wire [3:0] f_sync;
  wire [5:0] d_sync;
  wire drive_bus;
  reg [3:0] f_sel;
  reg [3:0] f_oe_periph;
  reg [5:0] d_sel;
  reg [5:0] d_out_periph;
  reg [5:0] d_oe_periph;
  reg [5:0] d_pullup;
  wire bus_write_drive;
  wire can_rx_mode;

  // Bus pins are driven only during an access unless the drive bit keeps them driven.
  assign drive_bus = ext_bus_active | bus_drive_control_bit; // [RULE1] [RULE8]
  assign bus_write_drive = drive_bus & ext_data_write; // [RULE1]
  assign can_rx_mode = port_d_peripheral_enable[`PDF_PIN1] &
    system_function_select[`PDF_SEL_PIN1_BIT];

  always @* begin
    // Port F: gpio enable clear selects the bus function, which is the reset default.
    f_sel = ~port_f_gpio_enable; // [RULE2]
    f_oe_periph = {`PDF_PORTF_W{bus_write_drive}}; // [RULE1]
  end

  always @* begin
    d_sel = port_d_peripheral_enable; // [RULE12]
    d_pullup = port_d_pullup_enable; // [RULE10]
    // A cleared pull-up bit must not leave a CAN receive line floating.
    if (can_rx_mode) begin
      d_pullup[`PDF_PIN1] = 1'b1; // [RULE11]
    end
  end

  always @* begin
    d_out_periph = `PDF_PORTD_ZERO;
    d_oe_periph = `PDF_PORTD_ZERO;
    // Pin 0: CAN transmit is open drain, so it drives only the dominant low.
    if (system_function_select[`PDF_SEL_PIN0_BIT]) begin // [RULE5]
      d_out_periph[`PDF_PIN0] = 1'b0;
      d_oe_periph[`PDF_PIN0] = ~can_second_transmit;
    end else begin
      d_out_periph[`PDF_PIN0] = chip_select_n[`PDF_CS_FOR_PIN0]; // [RULE7]
      d_oe_periph[`PDF_PIN0] = drive_bus; // [RULE8]
    end
    // Pin 1: CAN receive is an input only.
    if (system_function_select[`PDF_SEL_PIN1_BIT]) begin // [RULE6]
      d_out_periph[`PDF_PIN1] = 1'b0;
      d_oe_periph[`PDF_PIN1] = 1'b0;
    end else begin
      d_out_periph[`PDF_PIN1] = chip_select_n[`PDF_CS_FOR_PIN1]; // [RULE7]
      d_oe_periph[`PDF_PIN1] = drive_bus; // [RULE8]
    end
    d_out_periph[`PDF_PIN2] = chip_select_n[`PDF_CS_FOR_PIN2]; // [RULE7]
    d_oe_periph[`PDF_PIN2] = drive_bus; // [RULE8]
    d_out_periph[`PDF_PIN3] = chip_select_n[`PDF_CS_FOR_PIN3]; // [RULE7]
    d_oe_periph[`PDF_PIN3] = drive_bus; // [RULE8]
    d_out_periph[`PDF_PIN4] = chip_select_n[`PDF_CS_FOR_PIN4]; // [RULE7]
    d_oe_periph[`PDF_PIN4] = drive_bus; // [RULE8]
    d_out_periph[`PDF_PIN5] = chip_select_n[`PDF_CS_FOR_PIN5]; // [RULE7]
    d_oe_periph[`PDF_PIN5] = drive_bus; // [RULE8]
  end

  // Port F cells: the peripheral side is the external data bus.
  pdf_pin_cell u_cell_f0 (
    .clk(clk),
    .reset(reset),
    .periph_sel(f_sel[`PDF_PIN0]), // [RULE2]
    .gpio_dir(port_f_direction[`PDF_PIN0]), // [RULE4]
    .gpio_data(port_f_data_out[`PDF_PIN0]),
    .periph_out(ext_data_out[`PDF_PIN0]),
    .periph_oe(f_oe_periph[`PDF_PIN0]), // [RULE1]
    .pullup_en(port_f_pullup_enable[`PDF_PIN0]), // [RULE3]
    .pin_in(port_f_pin_in[`PDF_PIN0]),
    .pad_out(port_f_pin_out[`PDF_PIN0]),
    .pad_oe(port_f_pin_oe[`PDF_PIN0]),
    .pad_pullup(port_f_pin_pullup[`PDF_PIN0]),
    .pin_value(f_sync[`PDF_PIN0])
  );

  pdf_pin_cell u_cell_f1 (
    .clk(clk),
    .reset(reset),
    .periph_sel(f_sel[`PDF_PIN1]), // [RULE2]
    .gpio_dir(port_f_direction[`PDF_PIN1]), // [RULE4]
    .gpio_data(port_f_data_out[`PDF_PIN1]),
    .periph_out(ext_data_out[`PDF_PIN1]),
    .periph_oe(f_oe_periph[`PDF_PIN1]), // [RULE1]
    .pullup_en(port_f_pullup_enable[`PDF_PIN1]), // [RULE3]
    .pin_in(port_f_pin_in[`PDF_PIN1]),
    .pad_out(port_f_pin_out[`PDF_PIN1]),
    .pad_oe(port_f_pin_oe[`PDF_PIN1]),
    .pad_pullup(port_f_pin_pullup[`PDF_PIN1]),
    .pin_value(f_sync[`PDF_PIN1])
  );

  pdf_pin_cell u_cell_f2 (
    .clk(clk),
    .reset(reset),
    .periph_sel(f_sel[`PDF_PIN2]), // [RULE2]
    .gpio_dir(port_f_direction[`PDF_PIN2]), // [RULE4]
    .gpio_data(port_f_data_out[`PDF_PIN2]),
    .periph_out(ext_data_out[`PDF_PIN2]),
    .periph_oe(f_oe_periph[`PDF_PIN2]), // [RULE1]
    .pullup_en(port_f_pullup_enable[`PDF_PIN2]), // [RULE3]
    .pin_in(port_f_pin_in[`PDF_PIN2]),
    .pad_out(port_f_pin_out[`PDF_PIN2]),
    .pad_oe(port_f_pin_oe[`PDF_PIN2]),
    .pad_pullup(port_f_pin_pullup[`PDF_PIN2]),
    .pin_value(f_sync[`PDF_PIN2])
  );

  pdf_pin_cell u_cell_f3 (
    .clk(clk),
    .reset(reset),
    .periph_sel(f_sel[`PDF_PIN3]), // [RULE2]
    .gpio_dir(port_f_direction[`PDF_PIN3]), // [RULE4]
    .gpio_data(port_f_data_out[`PDF_PIN3]),
    .periph_out(ext_data_out[`PDF_PIN3]),
    .periph_oe(f_oe_periph[`PDF_PIN3]), // [RULE1]
    .pullup_en(port_f_pullup_enable[`PDF_PIN3]), // [RULE3]
    .pin_in(port_f_pin_in[`PDF_PIN3]),
    .pad_out(port_f_pin_out[`PDF_PIN3]),
    .pad_oe(port_f_pin_oe[`PDF_PIN3]),
    .pad_pullup(port_f_pin_pullup[`PDF_PIN3]),
    .pin_value(f_sync[`PDF_PIN3])
  );

  // Port D cells: the peripheral side is a chip select or the CAN lines.
  pdf_pin_cell u_cell_d0 (
    .clk(clk),
    .reset(reset),
    .periph_sel(d_sel[`PDF_PIN0]), // [RULE5]
    .gpio_dir(port_d_direction[`PDF_PIN0]), // [RULE4]
    .gpio_data(port_d_data_out[`PDF_PIN0]),
    .periph_out(d_out_periph[`PDF_PIN0]),
    .periph_oe(d_oe_periph[`PDF_PIN0]),
    .pullup_en(d_pullup[`PDF_PIN0]), // [RULE10]
    .pin_in(port_d_pin_in[`PDF_PIN0]),
    .pad_out(port_d_pin_out[`PDF_PIN0]),
    .pad_oe(port_d_pin_oe[`PDF_PIN0]),
    .pad_pullup(port_d_pin_pullup[`PDF_PIN0]),
    .pin_value(d_sync[`PDF_PIN0])
  );

  pdf_pin_cell u_cell_d1 (
    .clk(clk),
    .reset(reset),
    .periph_sel(d_sel[`PDF_PIN1]), // [RULE6]
    .gpio_dir(port_d_direction[`PDF_PIN1]), // [RULE4]
    .gpio_data(port_d_data_out[`PDF_PIN1]),
    .periph_out(d_out_periph[`PDF_PIN1]),
    .periph_oe(d_oe_periph[`PDF_PIN1]),
    .pullup_en(d_pullup[`PDF_PIN1]), // [RULE11]
    .pin_in(port_d_pin_in[`PDF_PIN1]),
    .pad_out(port_d_pin_out[`PDF_PIN1]),
    .pad_oe(port_d_pin_oe[`PDF_PIN1]),
    .pad_pullup(port_d_pin_pullup[`PDF_PIN1]),
    .pin_value(d_sync[`PDF_PIN1])
  );

  pdf_pin_cell u_cell_d2 (
    .clk(clk),
    .reset(reset),
    .periph_sel(d_sel[`PDF_PIN2]), // [RULE9]
    .gpio_dir(port_d_direction[`PDF_PIN2]), // [RULE4]
    .gpio_data(port_d_data_out[`PDF_PIN2]),
    .periph_out(d_out_periph[`PDF_PIN2]),
    .periph_oe(d_oe_periph[`PDF_PIN2]),
    .pullup_en(d_pullup[`PDF_PIN2]), // [RULE10]
    .pin_in(port_d_pin_in[`PDF_PIN2]),
    .pad_out(port_d_pin_out[`PDF_PIN2]),
    .pad_oe(port_d_pin_oe[`PDF_PIN2]),
    .pad_pullup(port_d_pin_pullup[`PDF_PIN2]),
    .pin_value(d_sync[`PDF_PIN2])
  );

  pdf_pin_cell u_cell_d3 (
    .clk(clk),
    .reset(reset),
    .periph_sel(d_sel[`PDF_PIN3]), // [RULE9]
    .gpio_dir(port_d_direction[`PDF_PIN3]), // [RULE4]
    .gpio_data(port_d_data_out[`PDF_PIN3]),
    .periph_out(d_out_periph[`PDF_PIN3]),
    .periph_oe(d_oe_periph[`PDF_PIN3]),
    .pullup_en(d_pullup[`PDF_PIN3]), // [RULE10]
    .pin_in(port_d_pin_in[`PDF_PIN3]),
    .pad_out(port_d_pin_out[`PDF_PIN3]),
    .pad_oe(port_d_pin_oe[`PDF_PIN3]),
    .pad_pullup(port_d_pin_pullup[`PDF_PIN3]),
    .pin_value(d_sync[`PDF_PIN3])
  );

  pdf_pin_cell u_cell_d4 (
    .clk(clk),
    .reset(reset),
    .periph_sel(d_sel[`PDF_PIN4]), // [RULE9]
    .gpio_dir(port_d_direction[`PDF_PIN4]), // [RULE4]
    .gpio_data(port_d_data_out[`PDF_PIN4]),
    .periph_out(d_out_periph[`PDF_PIN4]),
    .periph_oe(d_oe_periph[`PDF_PIN4]),
    .pullup_en(d_pullup[`PDF_PIN4]), // [RULE10]
    .pin_in(port_d_pin_in[`PDF_PIN4]),
    .pad_out(port_d_pin_out[`PDF_PIN4]),
    .pad_oe(port_d_pin_oe[`PDF_PIN4]),
    .pad_pullup(port_d_pin_pullup[`PDF_PIN4]),
    .pin_value(d_sync[`PDF_PIN4])
  );

  pdf_pin_cell u_cell_d5 (
    .clk(clk),
    .reset(reset),
    .periph_sel(d_sel[`PDF_PIN5]), // [RULE9]
    .gpio_dir(port_d_direction[`PDF_PIN5]), // [RULE4]
    .gpio_data(port_d_data_out[`PDF_PIN5]),
    .periph_out(d_out_periph[`PDF_PIN5]),
    .periph_oe(d_oe_periph[`PDF_PIN5]),
    .pullup_en(d_pullup[`PDF_PIN5]), // [RULE10]
    .pin_in(port_d_pin_in[`PDF_PIN5]),
    .pad_out(port_d_pin_out[`PDF_PIN5]),
    .pad_oe(port_d_pin_oe[`PDF_PIN5]),
    .pad_pullup(port_d_pin_pullup[`PDF_PIN5]),
    .pin_value(d_sync[`PDF_PIN5])
  );

  always @(posedge clk) begin
    if (reset) begin
      port_f_data_in <= `PDF_PORTF_ZERO;
    end else begin
      port_f_data_in <= f_sync; // [RULE4]
    end
  end

  // The bus view reads the same synchronised levels, so it never races the GPIO view.
  always @(posedge clk) begin
    if (reset) begin
      ext_data_in <= `PDF_PORTF_ZERO;
    end else begin
      ext_data_in <= f_sync;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      port_d_data_in <= `PDF_PORTD_ZERO;
    end else begin
      port_d_data_in <= d_sync; // [RULE4]
    end
  end

  // Receive reads recessive high whenever the pin is not handed to CAN receive.
  always @(posedge clk) begin
    if (reset) begin
      can_second_receive <= 1'b1;
    end else if (can_rx_mode) begin
      can_second_receive <= d_sync[`PDF_PIN1]; // [RULE6]
    end else begin
      can_second_receive <= 1'b1; // [RULE11]
    end
  end
endmodule // pdf_pin_mux

// ==== tb/pdf_chk.sv ====
// Checker for the pin function multiplexer.
`timescale 1ns/100ps
module pdf_chk (
  input wire logic clk, reset, bus_drive_control_bit, ext_bus_active, can_second_transmit,
  input wire logic [3:0] port_f_pullup_enable, port_f_gpio_enable, port_f_pin_oe,
  input wire logic [3:0] port_f_pin_pullup,
  input wire logic [5:0] port_d_pullup_enable, port_d_peripheral_enable, port_d_direction,
  input wire logic [5:0] port_d_pin_out, port_d_pin_oe, port_d_pin_pullup,
  input wire logic [7:0] system_function_select,
  input wire logic [7:2] chip_select_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire idle = !ext_bus_active && !bus_drive_control_bit;
  a_f_pull_off: assert property (!port_f_pullup_enable[0] |=> !port_f_pin_pullup[0])
    else $error("port f pull-up on");
  a_f_bus_float: assert property (!port_f_gpio_enable[1] && idle |=> !port_f_pin_oe[1])
    else $error("data pin driven");
  a_cs_float: assert property (port_d_peripheral_enable[3] && idle |=> !port_d_pin_oe[3])
    else $error("select driven");
  a_cs_follow: assert property (port_d_peripheral_enable[2] && bus_drive_control_bit |=>
    port_d_pin_oe[2] && port_d_pin_out[2] == $past(chip_select_n[4])) else $error("select lost");
  a_d_pull_off: assert property (!port_d_pullup_enable[2] |=> !port_d_pin_pullup[2])
    else $error("port d pull-up on");
  a_gpio_dir: assert property (!port_d_peripheral_enable[3] |=>
    port_d_pin_oe[3] == $past(port_d_direction[3])) else $error("direction lost");
  a_can_tx: assert property (port_d_peripheral_enable[0] && system_function_select[4] |=>
    port_d_pin_oe[0] != $past(can_second_transmit) && !port_d_pin_out[0]) else $error("tx bad");
  a_can_rx_pull: assert property (port_d_peripheral_enable[1] && system_function_select[5] |=>
    port_d_pin_pullup[1] && !port_d_pin_oe[1]) else $error("rx bad");
  c_can: cover property (port_d_peripheral_enable[0] && system_function_select[4]);
  c_cs: cover property (port_d_pin_oe[2] && port_d_peripheral_enable[2]);
  c_bus: cover property (port_f_pin_oe == 4'hF && !port_f_gpio_enable[0]);
endmodule // pdf_chk
bind pdf_pin_mux pdf_chk pdf_chk_i (.*);

// ==== tb/pdf_far.sv ====
// Far side of the pads: memory devices and CAN transceiver on the wires.
`timescale 1ns/100ps
module pdf_far (
  input wire logic clk,
  input wire logic [9:0] pad_out, pad_oe, pad_pu, far_oe, far_val,
  output logic [9:0] level
);
  logic [9:0] last = 10'h000;
  // A floating line without pull-up toggles, so a stale level never reads as valid.
  always_comb
    for (int i = 0; i < 10; i++)
      level[i] = far_oe[i] ? far_val[i] : pad_oe[i] ? pad_out[i] : pad_pu[i] | ~last[i];
  always @(posedge clk) last <= level;
endmodule // pdf_far

// ==== tb/pdf_pin_mux_bench.sv ====
// Self-checking bench for the pin function multiplexer.
`timescale 1ns/100ps
module pdf_pin_mux_bench;
  logic clk = 0, reset = 1, bus_drive_control_bit = 0, ext_bus_active = 0, ext_data_write = 0;
  logic can_second_transmit = 1, can_second_receive;
  logic [3:0] port_f_pullup_enable = 4'hF, port_f_gpio_enable = 4'h0, port_f_direction = 4'h0;
  logic [3:0] port_f_data_out = 4'h0, ext_data_out = 4'h0, port_f_pin_out, port_f_pin_oe;
  logic [3:0] port_f_pin_pullup, port_f_data_in, ext_data_in, port_f_pin_in;
  logic [5:0] port_d_pullup_enable = 6'h3F, port_d_peripheral_enable = 6'h00;
  logic [5:0] port_d_direction = 6'h00, port_d_data_out = 6'h00, port_d_pin_out, port_d_pin_oe;
  logic [5:0] port_d_pin_pullup, port_d_data_in, port_d_pin_in;
  logic [7:0] system_function_select = 8'h00;
  logic [7:2] chip_select_n = 6'h3F;
  logic [9:0] far_oe = 10'h000, far_val = 10'h000;
  wire [9:0] lvl;
  int bad_count = 0, cmp_count = 0;
  assign {port_d_pin_in, port_f_pin_in} = lvl;
  pdf_pin_mux pdf_pin_mux_i (.*);
  pdf_far pdf_far_i (.clk(clk), .pad_out({port_d_pin_out, port_f_pin_out}),
    .pad_oe({port_d_pin_oe, port_f_pin_oe}), .pad_pu({port_d_pin_pullup, port_f_pin_pullup}),
    .far_oe(far_oe), .far_val(far_val), .level(lvl));
  initial forever #2 clk = ~clk;
  task chk(input logic [5:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task t_bus;
    chk(port_f_pin_oe, 4'h0);
    @(posedge clk);
    {ext_bus_active, ext_data_write, ext_data_out} <= 6'h3A;
    tick(1);
    chk(port_f_pin_oe, 4'hF);
    chk(port_f_pin_out, 4'hA);
  endtask
  task t_gpio;
    @(posedge clk);
    {ext_bus_active, port_f_gpio_enable, port_f_direction, port_f_data_out} <= 13'h0F53;
    {port_f_pullup_enable, port_d_pullup_enable} <= 10'h3BB;
    {port_d_direction, port_d_data_out} <= 12'hF14;
    tick(1);
    chk(port_f_pin_oe, 4'h5);
    chk(port_f_pin_out & 4'h5, 4'h1);
    chk(port_f_pin_pullup, 4'hE);
    chk(port_d_pin_oe, 6'h3C);
    chk(port_d_pin_out & 6'h3C, 6'h14);
    chk(port_d_pin_pullup, 6'h3B);
    tick(5);
    chk(port_f_data_in, 4'hB);
    chk(ext_data_in, 4'hB);
    chk(port_d_data_in & 6'h3D, 6'h15);
  endtask
  task t_cs;
    @(posedge clk);
    {port_d_peripheral_enable, chip_select_n} <= 12'hF6A;
    tick(1);
    chk(port_d_pin_oe, 6'h00);
    @(posedge clk);
    bus_drive_control_bit <= 1;
    tick(1);
    chk(port_d_pin_oe, 6'h3D);
    chk(port_d_pin_out & 6'h3D, 6'h28);
    @(posedge clk);
    port_d_peripheral_enable <= 6'h00;
    tick(1);
    chk(port_d_pin_oe, 6'h3C);
  endtask
  task t_can;
    @(posedge clk);
    {port_d_peripheral_enable, port_d_pullup_enable} <= 12'h0C0;
    {system_function_select, can_second_transmit} <= 9'h060;
    tick(5);
    chk(port_d_pin_oe & 6'h03, 6'h01);
    chk(port_d_pin_pullup, 6'h02);
    chk(can_second_receive, 6'h01);
    @(posedge clk);
    far_oe <= 10'h020;
    tick(5);
    chk(can_second_receive, 6'h00);
    @(posedge clk);
    {far_oe, system_function_select} <= 18'h00010;
    tick(1);
    chk({port_d_pin_oe[1], port_d_pin_out[1]}, 6'h03);
    @(posedge clk);
    port_d_peripheral_enable <= 6'h00;
    tick(1);
    chk(port_d_pin_oe, 6'h3C);
  endtask
  task test_done;
    $display("compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 0;
    tick(1);
    t_bus;
    t_gpio;
    t_cs;
    t_can;
    test_done;
  end
  // The scenarios need under 60 cycles.
  initial begin
    #2000;
    bad_count++;
    test_done;
  end
endmodule // pdf_pin_mux_bench
